/* File: hdl/octal_switch_consts.svh */
// Constants of the eight-channel serial switch controller.
`ifndef OCTAL_SWITCH_CONSTS_SVH
`define OCTAL_SWITCH_CONSTS_SVH
`define OSW_WIDTH        8
`define OSW_MSB          7
`define OSW_ALL_OFF      8'hff
`define OSW_SHIFT_RESET  8'h00
`define OSW_CNT_RESET    4'h0
`endif

/* File: hdl/octal_switch_pkg.sv */
// Types shared by the eight-channel serial switch controller.
package octal_switch_pkg;
  // Synchronised link pins.
  typedef struct packed {
    logic sel_n;  // Chip select, active low.
    logic sclk;   // Serial clock level.
    logic sdi;    // Serial data input level.
  } link_pins_t;
  // Edge events found on the link.
  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
  } link_events_t;
endpackage : octal_switch_pkg

/* File: hdl/octal_switch_sync.sv */
// Two-stage synchroniser and edge finder for the serial link pins.
`timescale 1ns/1ns
module octal_switch_sync
  import octal_switch_pkg::*;
(
  input  wire  logic         clk,
  input  wire  logic         rst,
  input  wire  logic         ce,
  input  wire  link_pins_t   pins_in,
  output link_pins_t         pins,
  output link_events_t       events
);
  link_pins_t stage1;       // First stage, read only by stage two.
  link_pins_t stage2;       // Second stage, the settled level.
  link_pins_t prev;         // Settled level one cycle older.
  link_pins_t next_stage1;  // Next first stage.
  link_pins_t next_stage2;  // Next second stage.
  link_pins_t next_prev;    // Next old level.

  // Compute the next synchroniser values; idle levels select off, clock low.
  always_comb begin
    next_stage1 = pins_in;
    next_stage2 = stage1;
    next_prev   = stage2;
  end

  // Register the chain; reset loads the idle pattern.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 3'b100;
      stage2 <= 3'b100;
      prev   <= 3'b100;
    end else if (ce) begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      prev   <= next_prev;
    end
  end

  assign pins             = stage2;
  assign events.sclk_rise = stage2.sclk & ~prev.sclk;
  assign events.sclk_fall = ~stage2.sclk & prev.sclk;
  assign events.sel_fall  = ~stage2.sel_n & prev.sel_n;
  assign events.sel_rise  = stage2.sel_n & ~prev.sel_n;
endmodule : octal_switch_sync

/* File: hdl/octal_switch_serial_control.sv */
// Serial command and drain-status logic of an eight-channel low-side switch.
`timescale 1ns/1ns
`include "octal_switch_consts.svh"

module octal_switch_serial_control
  import octal_switch_pkg::*;
#(
  parameter int WIDTH = `OSW_WIDTH  // Channels and bits per frame.
)(
  input  wire  logic              CLK_SYS,
  input  wire  logic              SYS_RST,
  input  wire  logic              CE,
  input  wire  logic              CS_N,
  input  wire  logic              SCLK,
  input  wire  logic              SDI,
  input  wire  logic              RESET_N,
  input  wire  logic              SHORT_PROTECT_DISABLE,
  input  wire  logic [WIDTH-1:0]  SHORT_DETECT,
  input  wire  logic [WIDTH-1:0]  THERMAL_SHUTDOWN,
  input  wire  logic [WIDTH-1:0]  DRAIN_HIGH,
  output logic                    SDO,
  output logic                    SDO_OE,
  output logic [WIDTH-1:0]        OUT_ON,
  output logic [WIDTH-1:0]        OUT_LIMIT
);
  link_pins_t   pins_in;      // Raw link pins.
  link_pins_t   pins;         // Synchronised link pins.
  link_events_t ev;           // Edge events on the link.
  logic         rst_n_s1;     // Reset pin first stage.
  logic         rst_n_s2;     // Reset pin settled level.
  logic [WIDTH-1:0] prot_s1;  // Fault inputs, first stage (short).
  logic [WIDTH-1:0] prot_s2;  // Short detect, settled.
  logic [WIDTH-1:0] therm_s1; // Thermal flags, first stage.
  logic [WIDTH-1:0] therm_s2; // Thermal flags, settled.
  logic [WIDTH-1:0] drain_s1; // Drain comparators, first stage.
  logic [WIDTH-1:0] drain_s2; // Drain comparators, settled.
  logic         short_protect_disable_s1;      // Protect disable, first stage.
  logic         short_protect_disable_s2;      // Protect disable, settled.

  logic [WIDTH-1:0] shifter;       // Command/status shift register.
  logic [WIDTH-1:0] latch;         // Latched command, one means off.
  logic [WIDTH-1:0] tripped;       // Outputs latched off by a short.
  logic             sdo_bit;       // Registered serial data out.
  logic [3:0]       bit_count;     // Bits taken in this frame.
  logic [WIDTH-1:0] status_sr;     // Drain status on its way out; the reset pin never clears it.
  logic [WIDTH-1:0] next_shifter;
  logic [WIDTH-1:0] next_latch;
  logic [WIDTH-1:0] next_tripped;
  logic             next_sdo_bit;
  logic [3:0]       next_bit_count;
  logic [WIDTH-1:0] next_status_sr;

  assign pins_in = '{sel_n: CS_N, sclk: SCLK, sdi: SDI};

  // Link pins are crossed and edge-detected in the leaf module.
  octal_switch_sync u_sync (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .ce      (CE),
    .pins_in (pins_in),
    .pins    (pins),
    .events  (ev)
  );

  // Every other asynchronous pin passes two flip-flops before use.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rst_n_s1 <= 1'b0;
      rst_n_s2 <= 1'b0;
      prot_s1  <= '0;
      prot_s2  <= '0;
      therm_s1 <= '0;
      therm_s2 <= '0;
      drain_s1 <= '0;
      drain_s2 <= '0;
      short_protect_disable_s1  <= 1'b0;
      short_protect_disable_s2  <= 1'b0;
    end else if (CE) begin
      rst_n_s1 <= RESET_N;
      rst_n_s2 <= rst_n_s1;
      prot_s1  <= SHORT_DETECT;
      prot_s2  <= prot_s1;
      therm_s1 <= THERMAL_SHUTDOWN;
      therm_s2 <= therm_s1;
      drain_s1 <= DRAIN_HIGH;
      drain_s2 <= drain_s1;
      short_protect_disable_s1  <= SHORT_PROTECT_DISABLE;
      short_protect_disable_s2  <= short_protect_disable_s1;
    end
  end

  // Next values of the serial engine. Reset acts on the settled pin level at
  // once, needing no serial clock; the data-out path is left alone by it.
  always_comb begin
    next_shifter   = shifter;
    next_latch     = latch;
    next_tripped   = tripped;
    next_sdo_bit   = sdo_bit;
    next_bit_count = bit_count;
    next_status_sr = status_sr;
    // Drain status is loaded as the frame opens.
    // The status copy costs eight flip-flops, but it lets the reset pin clear
    // the command bits while data out keeps reporting the drains.
    if (ev.sel_fall) begin
      next_shifter   = drain_s2;
      next_status_sr = drain_s2;
      next_sdo_bit   = drain_s2[WIDTH-1];  // Output 7 appears first.
      next_bit_count = `OSW_CNT_RESET;
    end else if (!pins.sel_n) begin        // Deselected edges ignored.
      if (ev.sclk_rise) begin
        next_sdo_bit = status_sr[WIDTH-1]; // Data out moves on clock rise.
      end
      if (ev.sclk_fall) begin
        // Shift left so the first bit ends at output 7.
        next_shifter   = {shifter[WIDTH-2:0], pins.sdi};
        // The input trails the status out, so chained parts still see it.
        next_status_sr = {status_sr[WIDTH-2:0], pins.sdi};
        if (bit_count < 4'(WIDTH)) begin
          next_bit_count = bit_count + 4'h1;
        end
      end
    end
    if (ev.sel_rise) begin
      next_latch   = shifter;              // Frame end applies the word.
      next_tripped = '0;                   // A new write re-arms tripped outputs.
    end
    // Short with protection enabled drops just that output.
    if (!short_protect_disable_s2) begin
      next_tripped = next_tripped | (prot_s2 & ~next_latch);
    end
    // Reset wins over everything except the data-out bit, the status copy and the bit count.
    if (!rst_n_s2) begin
      next_shifter = `OSW_SHIFT_RESET;
      next_latch   = `OSW_ALL_OFF;
      next_tripped = '0;
    end
  end

  // Register the serial engine state.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      shifter   <= `OSW_SHIFT_RESET;
      latch     <= `OSW_ALL_OFF;
      tripped   <= '0;
      sdo_bit   <= 1'b0;
      bit_count <= `OSW_CNT_RESET;
      status_sr <= `OSW_SHIFT_RESET;
    end else if (CE) begin
      shifter   <= next_shifter;
      latch     <= next_latch;
      tripped   <= next_tripped;
      sdo_bit   <= next_sdo_bit;
      bit_count <= next_bit_count;
      status_sr <= next_status_sr;
    end
  end

  // Driver enabled only inside a frame.
  assign SDO    = sdo_bit;
  assign SDO_OE = ~pins.sel_n;
  // A zero in the latch turns the output on unless tripped or overheated.
  assign OUT_ON = ~latch & ~tripped & ~therm_s2;
  // Protect disabled: a short keeps the output on, current limited.
  assign OUT_LIMIT = OUT_ON & prot_s2 & {WIDTH{short_protect_disable_s2}};

  // Checks of the behaviour above.
  a_latch_on_rise: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && ev.sel_rise && rst_n_s2) |=> (latch == $past(shifter)))
    else $error("Latch did not take shifter at select rise.");
  a_status_load: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && ev.sel_fall && rst_n_s2) |=> (shifter == $past(drain_s2) && status_sr == $past(drain_s2)))
    else $error("Drain status not loaded at select fall.");
  a_status_no_reset: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && ev.sel_fall) |=> (sdo_bit == $past(drain_s2[WIDTH-1])))
    else $error("Data out first bit wrong at select fall.");
  a_full_frame: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && ev.sel_rise) |-> (bit_count == 4'(WIDTH)))
    else $error("Frame closed without a full word.");
  a_sdo_enable: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    SDO_OE == !pins.sel_n)
    else $error("Data out enable wrong.");
  a_shift_fall: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && !pins.sel_n && ev.sclk_fall && !ev.sel_fall && rst_n_s2)
      |=> (shifter[0] == $past(pins.sdi)))
    else $error("Input bit not captured on clock fall.");
  a_sdo_rise_only: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && !ev.sclk_rise && !ev.sel_fall) |=> $stable(sdo_bit))
    else $error("Data out changed without a clock rise.");
  a_reset_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && !rst_n_s2) |=> (OUT_ON == '0 && shifter == '0))
    else $error("Reset did not force outputs off.");
  a_idle_ignore: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && pins.sel_n && !ev.sel_rise && rst_n_s2) |=> $stable(shifter))
    else $error("Shifter moved while deselected.");
  a_trip_short: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (CE && !short_protect_disable_s2 && ((prot_s2 & ~latch) != '0) && !ev.sel_rise && rst_n_s2)
      |=> ((OUT_ON & $past(prot_s2 & ~latch)) == '0))
    else $error("Shorted output not dropped.");
endmodule : octal_switch_serial_control

/* File: dv/octal_switch_host.sv */
// Host-side serial master model that sends command frames and gathers status.
`timescale 1ns/1ns
module octal_switch_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // The link idles deselected with its clock low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // One eight-bit frame; a half period of four system clocks gives a 320 ns link period.
  task automatic frame(input logic [7:0] cmd, output logic [7:0] st);
    st = 8'h00;
    @(posedge clk) cs_n <= 1'b0;  // The clock is low across every select edge.
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin  // Output 7 goes first, output 0 last.
      repeat (2) @(posedge clk);
      sdi <= cmd[i];  // Data moves mid low phase, well clear of the rise.
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      // Status is read late in the high phase, after the rise has moved it.
      @(negedge clk) st[i] = sdo_oe ? sdo : 1'bx;  // An undriven line reads as unknown.
      @(posedge clk) sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : frame
  // Toggles clock and data while deselected; the clock ends low before any select edge.
  task automatic noise();
    repeat (6) begin
      repeat (4) @(posedge clk);
      sclk <= ~sclk;
      sdi  <= ~sdi;
    end
  endtask : noise
endmodule : octal_switch_host

/* File: dv/octal_switch_serial_control_bench.sv */
// Self-checking bench for the serial switch controller.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module octal_switch_serial_control_bench;
  typedef struct packed {
    logic [7:0] cmd;
    logic       short_protect_disable;
    logic [7:0] short_in;
    logic [7:0] therm;
    logic [7:0] on;
    logic [7:0] lim;
  } row_t;
  // Ordinary cases: all on, a mix, a latched short, a limited short, an overheated output.
  row_t       rows[5] = '{'{8'h00, 1'b0, 8'h00, 8'h00, 8'hff, 8'h00}, '{8'h5a, 1'b0, 8'h00, 8'h00, 8'ha5, 8'h00},
                          '{8'h00, 1'b0, 8'h10, 8'h00, 8'hef, 8'h00}, '{8'h00, 1'b1, 8'h10, 8'h00, 8'hff, 8'h10},
                          '{8'h0f, 1'b0, 8'h00, 8'h20, 8'hd0, 8'h00}};
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reset_n = 1'b1;
  logic       short_protect_disable    = 1'b0;
  logic [7:0] short_in = 8'h00;
  logic [7:0] therm   = 8'h00;
  logic [7:0] drain   = 8'hff;
  logic [7:0] st;
  wire        cs_n, sclk, sdi, sdo, sdo_oe;
  wire  [7:0] out_on, out_lim;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cycles = 0;
  // The system clock runs at 25 MHz.
  always #20 clk_sys = ~clk_sys;
  octal_switch_host i_octal_switch_host (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
                                         .sdo_oe(sdo_oe));
  octal_switch_serial_control i_octal_switch_serial_control (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(1'b1),
    .CS_N(cs_n), .SCLK(sclk), .SDI(sdi), .RESET_N(reset_n), .SHORT_PROTECT_DISABLE(short_protect_disable), .SHORT_DETECT(short_in),
    .THERMAL_SHUTDOWN(therm), .DRAIN_HIGH(drain), .SDO(sdo), .SDO_OE(sdo_oe), .OUT_ON(out_on), .OUT_LIMIT(out_lim));
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // Cuts a hang short; the whole sequence needs some 14200 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end
  // Main sequence: reset, the table of rows, then the awkward cases.
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("reset outputs", 8'h00, out_on)
    `CHK("reset enable", 1'b0, sdo_oe)
    foreach (rows[k]) begin
      @(posedge clk_sys);
      short_protect_disable     <= rows[k].short_protect_disable;
      short_in <= rows[k].short_in;
      therm    <= rows[k].therm;
      drain    <= ~rows[k].on;
      i_octal_switch_host.frame(rows[k].cmd, st);
      repeat (2600) @(posedge clk_sys);  // Repeat spaced beyond 100 us for valid status.
      i_octal_switch_host.frame(rows[k].cmd, st);
      `CHK("outputs", rows[k].on, out_on)
      `CHK("limit", rows[k].lim, out_lim)
      `CHK("status", ~rows[k].on, st)
      `CHK("idle enable", 1'b0, sdo_oe)
    end
    @(posedge clk_sys);
    short_protect_disable     <= 1'b0;
    short_in <= 8'h00;
    therm    <= 8'h00;
    drain    <= 8'h3c;
    // Deselected clock and data activity must leave the outputs alone.
    i_octal_switch_host.noise();
    repeat (8) @(posedge clk_sys);
    `CHK("deselected", 8'hf0, out_on)
    // Two quick identical writes check the link itself.
    i_octal_switch_host.frame(8'h3c, st);
    i_octal_switch_host.frame(8'h3c, st);
    `CHK("echo outputs", 8'hc3, out_on)
    `CHK("echo status", 8'h3c, st)
    // The device reset clears outputs without any link clocking, but status still flows.
    reset_n <= 1'b0;  // Held 3800 ns, across a whole frame, as after a load supply droop.
    repeat (10) @(posedge clk_sys);
    `CHK("reset pin", 8'h00, out_on)
    i_octal_switch_host.frame(8'h00, st);
    `CHK("status in reset", 8'h3c, st)
    `CHK("held off", 8'h00, out_on)
    reset_n <= 1'b1;
    final_report();
  end
endmodule : octal_switch_serial_control_bench
